// *** rtl/icm_pkg.sv ***
// Shared constants for the isolated CAN transceiver mode logic and its controller.
// Assumes a single 100 MHz clock on both ends.
package icm_pkg;
    localparam int          CLK_NS            = 10;
    // Timing figures in their own unit, then the cycle counts derived from them
    localparam int          WAKE_FILTER_NS    = 500;
    localparam int          WAKE_RESET_NS     = 40000;
    localparam int          DOM_LIMIT_NS      = 40000;
    localparam int          SLEEP_ENTRY_NS    = 30000;
    localparam int          SLEEP_EXIT_NS     = 30000;
    localparam logic [12:0] WAKE_FILTER_CYC   = 13'((WAKE_FILTER_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] WAKE_RESET_CYC    = 13'(WAKE_RESET_NS / CLK_NS);
    localparam logic [12:0] DOM_LIMIT_CYC     = 13'(DOM_LIMIT_NS / CLK_NS);
    localparam logic [12:0] SLEEP_ENTRY_CYC   = 13'((SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] SLEEP_EXIT_CYC    = 13'((SLEEP_EXIT_NS + CLK_NS - 1) / CLK_NS);
    // Controller register byte offsets
    localparam logic [3:0]  REG_CTRL          = 4'h0;
    localparam logic [3:0]  REG_TXBIT         = 4'h4;
    localparam logic [3:0]  REG_STATUS        = 4'h8;
    localparam logic [3:0]  REG_BITLEN        = 4'hC;
    // Field positions
    localparam int          CTRL_SLEEP        = 0;
    localparam int          CTRL_LISTEN       = 1;
    localparam int          CTRL_AUX          = 2;
    localparam int          ST_RX             = 0;
    localparam int          ST_LOST           = 1;
    localparam int          ST_SETTLE         = 2;
    localparam int          ST_EMPTY          = 3;
    localparam int          ST_FULL           = 4;
    localparam int          ST_BUSY           = 5;
    // Reset values
    localparam logic [2:0]  CTRL_RST          = 3'h0;
    localparam logic [15:0] BITLEN_RST        = 16'h0064;

    typedef enum logic [1:0] {
        ICM_WK_IDLE = 2'b00,
        ICM_WK_DOM  = 2'b01,
        ICM_WK_REC  = 2'b10,
        ICM_WK_DONE = 2'b11
    } icm_wake_t;

    typedef enum logic [0:0] {
        ICM_TX_IDLE = 1'b0,
        ICM_TX_BIT  = 1'b1
    } icm_tx_t;
endpackage

// *** rtl/icm_link_if.sv ***
// Logic-side pins between the CAN controller and the transceiver.
// No clock here; both ends run on the same clock given to each module.
interface icm_link_if;
    logic txd;
    logic rxd;
    logic low_power_select;
    logic listen_only;
    logic aux;

    modport dev (
        input  txd,
        input  low_power_select,
        input  listen_only,
        input  aux,
        output rxd
    );
    modport ctl (
        output txd,
        output low_power_select,
        output listen_only,
        output aux,
        input  rxd
    );
endinterface

// *** rtl/icm_transceiver.sv ***
// Transceiver end: mode control, driver gating, wake-up detection and readback.
// Assumes the bus level from the other nodes arrives synchronous to clk_i.
//
// What this block and the controller do
// - Low transmit is dominant; receive low is dominant
// - Bus dominant if any node drives dominant
// - Receive output follows resolved bus, not transmit
// - Controller yields bus after losing arbitration
// - Standby blocks transmit, driver floats to ground
// - Standby holds receive high until wake pattern
// - Controller keeps transmit high while modes settle
// - Slow dominant-recessive pattern within window wakes receiver
// - Wake pattern never ends standby by itself
// - After wake, forward bus data during standby
// - Listen-only ignores transmit, presents recessive only
// - Listen-only keeps receive path working normally
// - Cut long dominant; restore after transmit high
// - Aux output follows input, latched in standby
// - Edge-rate high sleeps transceiver only, not aux
module icm_transceiver
    import icm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    icm_link_if.dev   link,
    input  wire logic edge_rate_select_i,
    input  wire logic others_dom_i,
    output logic      drive_dom_o,
    output logic      bias_gnd_o,
    output logic      aux_out_o
);
    icm_wake_t   wake_q;
    logic [12:0] filt_q;
    logic [12:0] win_q;
    logic [12:0] dom_cnt_q;
    logic        dom_cut_q;
    logic        rxd_q;
    logic        trx_sleep;
    logic        bus_dom;

    // Either pin puts the transceiver to sleep; only the select pin touches aux
    assign trx_sleep = link.low_power_select | edge_rate_select_i;
    assign bus_dom   = drive_dom_o | others_dom_i;

    // Driver: sleep wins over listen-only, and both win over transmit data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_dom_o <= 1'b0;
            bias_gnd_o  <= 1'b0;
        end else begin
            bias_gnd_o <= trx_sleep;
            if (trx_sleep) begin
                drive_dom_o <= 1'b0;
            end else if (link.listen_only) begin
                drive_dom_o <= 1'b0;
            end else begin
                drive_dom_o <= ~link.txd & ~dom_cut_q;
            end
        end
    end

    // Dominant timeout; a stuck-low transmit line cannot hold the bus forever
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dom_cnt_q <= 13'h0000;
            dom_cut_q <= 1'b0;
        end else if (link.txd) begin
            dom_cnt_q <= 13'h0000;
            dom_cut_q <= 1'b0;
        end else if (dom_cnt_q >= DOM_LIMIT_CYC) begin
            dom_cut_q <= 1'b1;
        end else begin
            dom_cnt_q <= dom_cnt_q + 13'h0001;
        end
    end

    // Wake detector: dominant then recessive, each at least the filter time,
    // all inside the reset window. Leaving standby is the only way out of DONE.
    always_ff @(posedge clk_i) begin
        if (rst_i || !trx_sleep) begin
            wake_q <= ICM_WK_IDLE;
            filt_q <= 13'h0000;
            win_q  <= 13'h0000;
        end else begin
            case (wake_q)
                ICM_WK_IDLE: begin
                    filt_q <= 13'h0000;
                    win_q  <= 13'h0000;
                    if (bus_dom) begin
                        wake_q <= ICM_WK_DOM;
                    end
                end
                ICM_WK_DOM: begin
                    win_q <= win_q + 13'h0001;
                    if (win_q >= WAKE_RESET_CYC) begin
                        wake_q <= ICM_WK_IDLE;
                    end else if (bus_dom) begin
                        filt_q <= filt_q + 13'h0001;
                    end else if (filt_q >= WAKE_FILTER_CYC) begin
                        wake_q <= ICM_WK_REC;
                        filt_q <= 13'h0000;
                    end else begin
                        wake_q <= ICM_WK_IDLE;
                    end
                end
                ICM_WK_REC: begin
                    win_q <= win_q + 13'h0001;
                    if (win_q >= WAKE_RESET_CYC) begin
                        wake_q <= ICM_WK_IDLE;
                    end else if (!bus_dom) begin
                        filt_q <= filt_q + 13'h0001;
                        if (filt_q >= WAKE_FILTER_CYC) begin
                            wake_q <= ICM_WK_DONE;
                        end
                    end else begin
                        wake_q <= ICM_WK_DOM;
                        filt_q <= 13'h0000;
                    end
                end
                default: begin
                    wake_q <= ICM_WK_DONE;
                end
            endcase
        end
    end

    // Receive path reads the resolved bus in every awake mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxd_q <= 1'b1;
        end else if (trx_sleep && wake_q != ICM_WK_DONE) begin
            rxd_q <= 1'b1;
        end else begin
            rxd_q <= ~bus_dom;
        end
    end
    assign link.rxd = rxd_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_out_o <= 1'b0;
        end else if (!link.low_power_select) begin
            aux_out_o <= link.aux;
        end
    end
endmodule

// *** rtl/icm_controller.sv ***
// Controller end: Wishbone registers, two-entry bit buffer, bit transmitter.
// Assumes classic Wishbone with the same clock; bits are sent one per bit period.
module icm_controller
    import icm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    icm_link_if.ctl          link,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o
);
    logic [2:0]  ctrl_q;
    logic [15:0] bitlen_q;
    logic        lost_q;
    logic [12:0] settle_q;
    logic        sleep_seen_q;
    logic [1:0]  buf_q;
    logic        rd_ptr_q;
    logic        wr_ptr_q;
    logic [1:0]  cnt_q;
    icm_tx_t     tx_q;
    logic [15:0] tick_q;
    logic        txd_q;
    logic        req;
    logic        push;
    logic        pop;
    logic        in_ready;
    logic        out_valid;
    logic        settling;
    logic        lost_set;
    logic        sleep_edge;

    assign req       = cyc_i & stb_i & ~ack_o;
    assign in_ready  = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign settling  = (settle_q != 13'h0000);
    // A write to the bit register waits for room; this is the back-pressure
    assign push      = req & we_i & sel_i[0] & (adr_i == REG_TXBIT) & in_ready;
    // The flip cycle itself counts too: the settle timer only loads one edge later
    assign sleep_edge = ctrl_q[CTRL_SLEEP] ^ sleep_seen_q;
    assign pop       = out_valid & (tx_q == ICM_TX_IDLE) & ~settling & ~sleep_edge & ~lost_q;
    // Sending recessive but reading dominant at the bit end: arbitration lost
    assign lost_set  = (tx_q == ICM_TX_BIT) & (tick_q == 16'h0000) & txd_q
                       & ~link.rxd & ~settling;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (req && !(we_i && sel_i[0] && adr_i == REG_TXBIT && !in_ready)) begin
            ack_o <= 1'b1;
        end else begin
            ack_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            if (adr_i == REG_CTRL) begin
                dat_o <= {29'h0000_0000, ctrl_q};
            end else if (adr_i == REG_STATUS) begin
                dat_o <= {26'h0000_0000, (tx_q == ICM_TX_BIT), ~in_ready, ~out_valid,
                          settling, lost_q, link.rxd | settling};
            end else if (adr_i == REG_BITLEN) begin
                dat_o <= {16'h0000, bitlen_q};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q   <= CTRL_RST;
            bitlen_q <= BITLEN_RST;
        end else if (req && we_i) begin
            if (adr_i == REG_CTRL && sel_i[0]) begin
                ctrl_q <= dat_i[2:0];
            end else if (adr_i == REG_BITLEN) begin
                if (sel_i[0]) bitlen_q[7:0] <= dat_i[7:0];
                if (sel_i[1]) bitlen_q[15:8] <= dat_i[15:8];
            end
        end
    end

    // Lost flag: a new loss in the clearing cycle keeps the flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lost_q <= 1'b0;
        end else if (lost_set) begin
            lost_q <= 1'b1;
        end else if (req && we_i && sel_i[0] && adr_i == REG_STATUS && dat_i[ST_LOST]) begin
            lost_q <= 1'b0;
        end
    end

    // Settle timer restarts on every change of the sleep request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_seen_q <= 1'b0;
            settle_q     <= 13'h0000;
        end else begin
            sleep_seen_q <= ctrl_q[CTRL_SLEEP];
            if (ctrl_q[CTRL_SLEEP] && !sleep_seen_q) begin
                settle_q <= SLEEP_ENTRY_CYC;
            end else if (!ctrl_q[CTRL_SLEEP] && sleep_seen_q) begin
                settle_q <= SLEEP_EXIT_CYC;
            end else if (settling) begin
                settle_q <= settle_q - 13'h0001;
            end
        end
    end

    // Two-entry buffer; a lost arbitration flushes what was queued
    always_ff @(posedge clk_i) begin
        if (rst_i || lost_set) begin
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            cnt_q    <= 2'd0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_q] <= dat_i[0];
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end

    // Bit transmitter; transmit idles recessive, and a sleep change, settling or loss forces it so
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_q   <= ICM_TX_IDLE;
            tick_q <= 16'h0000;
            txd_q  <= 1'b1;
        end else begin
            case (tx_q)
                ICM_TX_IDLE: begin
                    txd_q <= 1'b1;
                    if (pop) begin
                        tx_q   <= ICM_TX_BIT;
                        txd_q  <= buf_q[rd_ptr_q];
                        tick_q <= bitlen_q - 16'h0001;
                    end
                end
                default: begin
                    if (lost_set || settling || sleep_edge) begin
                        tx_q  <= ICM_TX_IDLE;
                        txd_q <= 1'b1;
                    end else if (tick_q == 16'h0000) begin
                        tx_q  <= ICM_TX_IDLE;
                        txd_q <= 1'b1;
                    end else begin
                        tick_q <= tick_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign link.txd              = txd_q;
    assign link.low_power_select = ctrl_q[CTRL_SLEEP];
    assign link.listen_only      = ctrl_q[CTRL_LISTEN];
    assign link.aux              = ctrl_q[CTRL_AUX];
endmodule

// *** tb/icm_link_assertions.sv ***
// Checker on the link signals and the transceiver's bus-side outputs.
// Assumes one clock, synchronous active-high reset; the bench instantiates it.
module icm_link_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic txd,
    input wire logic rxd,
    input wire logic low_power_select,
    input wire logic listen_only,
    input wire logic aux,
    input wire logic edge_rate_select_i,
    input wire logic others_dom_i,
    input wire logic drive_dom_o,
    input wire logic bias_gnd_o,
    input wire logic aux_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] dom_cnt_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Saturates, so a long dominant bus in standby cannot wrap it back below the filter
    always_ff @(posedge clk_i) begin
        if (rst_i || !low_power_select) begin
            dom_cnt_q <= 6'h00;
        end else if (others_dom_i && dom_cnt_q != 6'h3F) begin
            dom_cnt_q <= dom_cnt_q + 6'h01;
        end
    end

    a_recessive_no_drive: assert property (txd |=> !drive_dom_o)
        else $error("drive without dominant request");
    a_dominant_drives: assert property (!txd && $past(txd) && !low_power_select && !listen_only
        && !edge_rate_select_i |=> drive_dom_o) else $error("dominant request not driven");
    a_standby_floats: assert property (low_power_select || edge_rate_select_i
        |=> !drive_dom_o && bias_gnd_o) else $error("standby driver not floated");
    a_listen_recessive: assert property (listen_only |=> !drive_dom_o)
        else $error("listen-only drove the bus");
    a_rx_follows_bus: assert property (!low_power_select && !edge_rate_select_i
        |=> rxd == !$past(drive_dom_o | others_dom_i)) else $error("receive not bus");
    a_standby_rx_quiet: assert property (low_power_select && $past(low_power_select)
        && !rxd |-> dom_cnt_q > 6'h32) else $error("receive woke without pattern");
    a_wake_forwards: assert property (low_power_select && $past(low_power_select)
        && !rxd |-> $past(others_dom_i)) else $error("woken receive not bus");
    a_aux_follows: assert property (!low_power_select |=> aux_out_o == $past(aux))
        else $error("aux output not following");
    a_aux_latched: assert property (low_power_select |=> $stable(aux_out_o))
        else $error("aux output moved in standby");
    a_settle_txd_high: assert property ($changed(low_power_select) |=> txd [*8])
        else $error("transmit low while settling");

    c_wake: cover property (low_power_select && !rxd);
    c_listen_rx: cover property (listen_only && !rxd);
    c_tx_dom: cover property (drive_dom_o && !rxd);
endmodule

// *** tb/tb_isolated_can_phy_mode_control.sv ***
// Bench for controller and transceiver joined by the link interface.
// Assumes 100 MHz; odom stands for every other node on the bus.
module tb_isolated_can_phy_mode_control import icm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        ers = 1'b0;
    logic        odom = 1'b0;
    logic        ack, drv, bias, auxo;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, q;
    int          fails = 0;
    int          tests_run = 0;

    icm_link_if link();
    icm_transceiver icm_transceiver_i (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .edge_rate_select_i(ers), .others_dom_i(odom), .drive_dom_o(drv),
        .bias_gnd_o(bias), .aux_out_o(auxo));
    icm_controller icm_controller_i (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
    icm_link_assertions icm_link_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
        .txd(link.txd), .rxd(link.rxd), .low_power_select(link.low_power_select),
        .listen_only(link.listen_only), .aux(link.aux), .edge_rate_select_i(ers),
        .others_dom_i(odom), .drive_dom_o(drv), .bias_gnd_o(bias), .aux_out_o(auxo));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // A full buffer holds off ack for a whole bit, hence the generous bound
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 5000);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            final_report();
        end
    endtask

    task automatic wait_txd(input logic v);
        int n;
        n = 0;
        while (link.txd !== v && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        if (link.txd !== v) begin
            fails++;
            final_report();
        end
    endtask

    task automatic t_regs();
        wb(1'b0, REG_CTRL, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, REG_BITLEN, 32'h0000_0000);
        chk(q, 32'h0000_0064);
        wb(1'b1, 4'h2, 32'hFFFF_FFFF);
        wb(1'b0, 4'h2, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_fill();
        int n;
        repeat (4) wb(1'b1, REG_TXBIT, 32'h0000_0001);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(q[ST_FULL], 1'b1);
        n = 0;
        do begin
            wb(1'b0, REG_STATUS, 32'h0000_0000);
            n++;
        end while (!(q[ST_EMPTY] === 1'b1 && q[ST_BUSY] === 1'b0) && n < 200);
        chk(q[ST_EMPTY], 1'b1);
        chk(link.txd, 1'b1);
        $display("test fill done");
    endtask

    task automatic t_dom();
        wb(1'b1, REG_TXBIT, 32'h0000_0000);
        wait_txd(1'b0);
        tick(3);
        chk(drv, 1'b1);
        chk(link.rxd, 1'b0);
        odom <= 1'b1;
        tick(3);
        chk(link.rxd, 1'b0);
        odom <= 1'b0;
        wait_txd(1'b1);
        tick(3);
        chk(link.rxd, 1'b1);
        $display("test dominant done");
    endtask

    task automatic t_arb();
        odom <= 1'b1;
        wb(1'b1, REG_TXBIT, 32'h0000_0001);
        tick(150);
        odom <= 1'b0;
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(q[ST_LOST], 1'b1);
        chk(link.txd, 1'b1);
        wb(1'b1, REG_STATUS, 32'h0000_0002);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(q[ST_LOST], 1'b0);
        $display("test arbitration done");
    endtask

    task automatic t_listen();
        wb(1'b1, REG_CTRL, 32'h0000_0002);
        wb(1'b1, REG_TXBIT, 32'h0000_0000);
        wait_txd(1'b0);
        tick(3);
        chk(drv, 1'b0);
        odom <= 1'b1;
        tick(3);
        chk(link.rxd, 1'b0);
        odom <= 1'b0;
        wait_txd(1'b1);
        $display("test listen done");
    endtask

    task automatic t_standby();
        wb(1'b1, REG_CTRL, 32'h0000_0004);
        tick(3);
        chk(auxo, 1'b1);
        wb(1'b1, REG_CTRL, 32'h0000_0003);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        chk(q[ST_SETTLE], 1'b1);
        chk(q[ST_RX], 1'b1);
        // A bit queued now must wait until the exit settle time, which restarts the timer, runs out
        wb(1'b1, REG_TXBIT, 32'h0000_0000);
        tick(3);
        chk(link.txd, 1'b1);
        chk(bias, 1'b1);
        chk(drv, 1'b0);
        chk(auxo, 1'b1);
        odom <= 1'b1;
        tick(20);
        chk(link.rxd, 1'b1);
        odom <= 1'b0;
        tick(20);
        odom <= 1'b1;
        tick(60);
        odom <= 1'b0;
        tick(60);
        odom <= 1'b1;
        tick(3);
        chk(link.rxd, 1'b0);
        odom <= 1'b0;
        tick(3);
        chk(link.rxd, 1'b1);
        chk(bias, 1'b1);
        wb(1'b1, REG_CTRL, 32'h0000_0004);
        tick(2990);
        chk(link.txd, 1'b1);
        chk(bias, 1'b0);
        tick(20);
        chk(link.txd, 1'b0);
        chk(drv, 1'b1);
        wait_txd(1'b1);
        $display("test standby done");
    endtask

    task automatic t_rate();
        ers <= 1'b1;
        wb(1'b1, REG_CTRL, 32'h0000_0000);
        tick(3);
        chk(bias, 1'b1);
        chk(auxo, 1'b0);
        ers <= 1'b0;
        tick(3);
        chk(bias, 1'b0);
        $display("test edge rate done");
    endtask

    // A bit longer than the dominant limit is cut; the next one drives again
    task automatic t_limit();
        wb(1'b1, REG_BITLEN, 32'h0000_1004);
        wb(1'b0, REG_BITLEN, 32'h0000_0000);
        chk(q, 32'h0000_1004);
        wb(1'b1, REG_TXBIT, 32'h0000_0000);
        wait_txd(1'b0);
        tick(3);
        chk(drv, 1'b1);
        tick(4010);
        chk(link.txd, 1'b0);
        chk(drv, 1'b0);
        wait_txd(1'b1);
        wb(1'b1, REG_BITLEN, 32'h0000_0064);
        wb(1'b1, REG_TXBIT, 32'h0000_0000);
        wait_txd(1'b0);
        tick(3);
        chk(drv, 1'b1);
        wait_txd(1'b1);
        $display("test dominant limit done");
    endtask

    initial begin
        tick(2);
        rst_i <= 1'b0;
        t_regs();
        t_fill();
        t_dom();
        t_arb();
        t_listen();
        t_standby();
        t_rate();
        t_limit();
        final_report();
    end
endmodule
